// [rtl/lvdc_consts.svh]
// Constants of the supply voltage detector control block: offsets, fields, resets, timing
`ifndef LVDC_CONSTS_SVH
`define LVDC_CONSTS_SVH

// Register byte addresses on the CPU data space
`define LVDC_ADDR_W 20
`define LVDC_CTRL_ADDR 20'hfffa9
`define LVDC_LEVEL_ADDR 20'hfffaa

// Control register fields
`define LVDC_EN_BIT 7
`define LVDC_MASK_BIT 1
`define LVDC_FLAG_BIT 0
`define LVDC_CTRL_RESET 8'h00

// Level-select register fields
`define LVDC_LMODE_BIT 7
`define LVDC_LLEVEL_BIT 0
`define LVDC_LEVEL_INIT_IRQ 8'h01
`define LVDC_LEVEL_INIT_OTHER 8'h81

// Option-byte mode pair codes {hi, lo}
`define LVDC_MODE_OFF_CODE 2'h0
`define LVDC_MODE_IRQ_CODE 2'h1
`define LVDC_MODE_COMB_CODE 2'h2
`define LVDC_MODE_RST_CODE 2'h3

// Threshold settling wait, least time, rounded up to whole cycles
`define LVDC_CLK_MHZ 125
`define LVDC_SETTLE_NS 300
`define LVDC_SETTLE_CYC ((`LVDC_SETTLE_NS * `LVDC_CLK_MHZ + 999) / 1000)
`define LVDC_CNT_W 6

`endif

// [rtl/lvdc_pkg.sv]
// Types shared by the supply voltage detector control block
`default_nettype none
`include "lvdc_consts.svh"

package lvdc_pkg;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    LVDC_ST_LOAD = 3'h1,
    LVDC_ST_HOLD = 3'h2,
    LVDC_ST_RUN = 3'h4
  } lvdc_st_t;

  // Operating mode taken from the option byte
  typedef enum logic [1:0] {
    LVDC_MODE_OFF = `LVDC_MODE_OFF_CODE,
    LVDC_MODE_IRQ = `LVDC_MODE_IRQ_CODE,
    LVDC_MODE_COMB = `LVDC_MODE_COMB_CODE,
    LVDC_MODE_RST = `LVDC_MODE_RST_CODE
  } lvdc_mode_t;

  // Whole state of the synchroniser
  typedef struct packed {
    logic meta;
    logic q;
  } lvdc_sync_t;

  // Whole state of the control block
  typedef struct packed {
    lvdc_st_t st;
    lvdc_mode_t mode;
    logic det_reset;
    logic rewrite_en;
    logic [7:0] level;
    logic below_q;
    logic [`LVDC_CNT_W-1:0] settle_cnt;
    logic irq;
    logic int_reset;
    logic [7:0] rdata;
  } lvdc_state_t;

endpackage

`default_nettype wire

// [rtl/lvdc_sync.sv]
// Two-flop synchroniser for one level arriving from outside the clock domain
`default_nettype none

module lvdc_sync (
  input wire logic core_clk,
  input wire logic async_in,
  output logic sync_out
);

  // Both stages, no reset: a reset would blank static straps for two cycles
  lvdc_pkg::lvdc_sync_t s;
  lvdc_pkg::lvdc_sync_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Next stage values; first stage feeds only the second
  always_comb begin
    next_s.meta = async_in;
    next_s.q = s.meta;
  end

  // Register the copy
  always_ff @(posedge core_clk) begin
    s <= next_s;
  end

  assign sync_out = s.q;

endmodule

`default_nettype wire

// [rtl/lvdc_top.sv]
// Control and status logic of the on-chip supply voltage detector
// How it works
// - Control register takes bit and byte writes
// - Reset clears control, unless detector caused it
// - Non-detector reset clears rewrite enable; level reloaded from mode
// - Bit 7 gates level writes; mask follows
// - Bit 1 reports detector output masked
// - Bit 0 set while supply below threshold and detector not off
// - Mask and flag bits ignore writes
// - Enable settable only in combined mode
// - Combined mode masks during enable and settling
// - Mode and level come from option bits
// - Interrupt mode starts disabled, level 01H
// - Interrupt mode holds reset until supply rises
// - After release, rising supply raises interrupt
//
// Strobed register access was chosen for this implementation.
`default_nettype none
`include "lvdc_consts.svh"

module lvdc_top (
  input wire logic core_clk,
  input wire logic rst,
  // Level: the reset now asserted was caused by the detector
  input wire logic reset_by_detector,
  // Raw comparator output, high while supply is below threshold
  input wire logic supply_below_raw,
  // Option-byte mode pair, static straps
  input wire logic detector_mode_opt_hi,
  input wire logic detector_mode_opt_lo,
  // Register port
  input wire logic [`LVDC_ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_wmask,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // Detector results
  output logic supply_detect_irq,
  output logic detector_internal_reset,
  output logic [7:0] detect_level_select
);

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised pin levels
  logic below_s; // Comparator after two flops
  logic opt_hi_s; // Mode bit high after two flops
  logic opt_lo_s; // Mode bit low after two flops

  // Comparator output is asynchronous to core_clk
  lvdc_sync u_sync_below (
    .core_clk(core_clk),
    .async_in(supply_below_raw),
    .sync_out(below_s)
  );

  // Option straps come from flash, another timing world
  lvdc_sync u_sync_opt_hi (
    .core_clk(core_clk),
    .async_in(detector_mode_opt_hi),
    .sync_out(opt_hi_s)
  );

  lvdc_sync u_sync_opt_lo (
    .core_clk(core_clk),
    .async_in(detector_mode_opt_lo),
    .sync_out(opt_lo_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State
  lvdc_pkg::lvdc_state_t s; // Registered state
  lvdc_pkg::lvdc_state_t next_s; // Next state

  // Derived status, combinational from state and bus inputs
  logic comb_mode; // Combined interrupt and reset mode active
  logic masked; // Detector output masked
  logic flag; // Supply below threshold and detector on
  logic ctrl_hit; // Access hits the control register
  logic level_hit; // Access hits the level register
  logic [7:0] new_level; // Level after a masked write
  logic [`LVDC_CNT_W-1:0] settle_load; // Settling wait in cycles

  // Wait length from the clock rate; six bits leave headroom for a faster clock
  assign settle_load = `LVDC_CNT_W'(`LVDC_SETTLE_CYC);
  assign comb_mode = (s.mode == lvdc_pkg::LVDC_MODE_COMB);
  assign ctrl_hit = (bus_addr == `LVDC_CTRL_ADDR);
  assign level_hit = (bus_addr == `LVDC_LEVEL_ADDR);

  // Mask only exists in combined mode; enable or a running wait sets it
  assign masked = comb_mode && (s.rewrite_en || (s.settle_cnt != '0));

  // Off detector never reports low supply
  assign flag = below_s && (s.mode != lvdc_pkg::LVDC_MODE_OFF);

  // Only the mode and level bits of the level register exist
  always_comb begin
    new_level = 8'h00;
    new_level[`LVDC_LMODE_BIT] = bus_wmask[`LVDC_LMODE_BIT] ? bus_wdata[`LVDC_LMODE_BIT]
                                                            : s.level[`LVDC_LMODE_BIT];
    new_level[`LVDC_LLEVEL_BIT] = bus_wmask[`LVDC_LLEVEL_BIT] ? bus_wdata[`LVDC_LLEVEL_BIT]
                                                              : s.level[`LVDC_LLEVEL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  // Bus writes follow the sequencer, so a write wins over a running wait
  always_comb begin
    next_s = s;
    next_s.irq = 1'b0;
    next_s.rdata = 8'h00;
    // Settling wait runs down by itself
    if (s.settle_cnt != '0) begin
      next_s.settle_cnt = s.settle_cnt - `LVDC_CNT_W'(1);
    end
    if (rst) begin
      // Remember who reset us; the load step needs it
      next_s.st = lvdc_pkg::LVDC_ST_LOAD;
      next_s.det_reset = reset_by_detector;
      next_s.settle_cnt = '0;
      next_s.int_reset = 1'b0;
      // Detector reset keeps control and level as they are
      if (!reset_by_detector) begin
        // Only bit 7 of the reset value matters here
        next_s.rewrite_en = 1'(`LVDC_CTRL_RESET >> `LVDC_EN_BIT);
      end
    end else begin
      case (s.st)
        lvdc_pkg::LVDC_ST_LOAD: begin
          // Straps settled while reset was held; take mode now
          next_s.mode = lvdc_pkg::lvdc_mode_t'({opt_hi_s, opt_lo_s});
          next_s.below_q = below_s;
          if (!s.det_reset) begin
            // Fresh start: level from mode
            if ({opt_hi_s, opt_lo_s} == `LVDC_MODE_IRQ_CODE) begin
              next_s.level = `LVDC_LEVEL_INIT_IRQ;
            end else begin
              next_s.level = `LVDC_LEVEL_INIT_OTHER;
            end
          end
          // Enable cannot survive outside combined mode
          if ({opt_hi_s, opt_lo_s} != `LVDC_MODE_COMB_CODE) begin
            next_s.rewrite_en = 1'b0;
          end
          if ({opt_hi_s, opt_lo_s} == `LVDC_MODE_IRQ_CODE) begin
            // Interrupt mode: hold the internal reset first
            next_s.int_reset = 1'b1;
            next_s.st = lvdc_pkg::LVDC_ST_HOLD;
          end else begin
            next_s.st = lvdc_pkg::LVDC_ST_RUN;
          end
        end
        lvdc_pkg::LVDC_ST_HOLD: begin
          next_s.below_q = below_s;
          // Release once the supply is first above threshold; no interrupt for this
          if (!below_s) begin
            next_s.int_reset = 1'b0;
            next_s.st = lvdc_pkg::LVDC_ST_RUN;
          end
        end
        lvdc_pkg::LVDC_ST_RUN: begin
          next_s.below_q = below_s;
          case (s.mode)
            lvdc_pkg::LVDC_MODE_IRQ: begin
              // Rising supply crosses threshold
              if (s.below_q && !below_s) begin
                next_s.irq = 1'b1;
              end
            end
            lvdc_pkg::LVDC_MODE_COMB: begin
              // Falling supply raises an interrupt unless masked, then waits
              if (!s.below_q && below_s && !masked) begin
                next_s.irq = 1'b1;
                next_s.settle_cnt = settle_load;
              end
            end
            lvdc_pkg::LVDC_MODE_RST: begin
              // Reset mode: internal reset follows the comparator
              next_s.int_reset = below_s;
            end
            default: begin
              next_s.int_reset = 1'b0;
            end
          endcase
        end
        default: begin
          next_s.st = lvdc_pkg::LVDC_ST_LOAD;
        end
      endcase
      // Register writes; bit writes arrive as a one-bit mask
      if (bus_wr && ctrl_hit) begin
        // Only bit 7 is writable, and only in combined mode
        if (bus_wmask[`LVDC_EN_BIT] && comb_mode) begin
          next_s.rewrite_en = bus_wdata[`LVDC_EN_BIT];
        end
      end
      if (bus_wr && level_hit && s.rewrite_en) begin
        // Level register is locked while enable is clear
        next_s.level = new_level;
        if (comb_mode && (new_level[`LVDC_LLEVEL_BIT] != s.level[`LVDC_LLEVEL_BIT])) begin
          // New threshold needs time to settle; masked meanwhile
          next_s.settle_cnt = settle_load;
        end
      end
      // Read data stand in the next cycle only
      if (bus_rd && ctrl_hit) begin
        next_s.rdata[`LVDC_EN_BIT] = s.rewrite_en;
        next_s.rdata[`LVDC_MASK_BIT] = masked;
        next_s.rdata[`LVDC_FLAG_BIT] = flag;
      end else if (bus_rd && level_hit) begin
        next_s.rdata = s.level;
      end
    end
  end

  // Register the whole state
  always_ff @(posedge core_clk) begin
    s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from flops
  assign bus_rdata = s.rdata;
  assign supply_detect_irq = s.irq;
  assign detector_internal_reset = s.int_reset;
  assign detect_level_select = s.level;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  // Checks sleep during reset; the load step is checked at its own edge
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Read of the control register
  sequence ctrl_read_s;
    bus_rd && ctrl_hit;
  endsequence

  // Supply rises through threshold in interrupt mode
  sequence rise_s;
    s.st == lvdc_pkg::LVDC_ST_RUN && s.mode == lvdc_pkg::LVDC_MODE_IRQ && s.below_q && !below_s;
  endsequence

  // Level bit changed by a permitted write in combined mode
  sequence level_flip_s;
    bus_wr && level_hit && s.rewrite_en && comb_mode &&
      (new_level[`LVDC_LLEVEL_BIT] != s.level[`LVDC_LLEVEL_BIT]);
  endsequence

  // Non-detector reset leaves enable clear
  reset_clear_a: assert property ($fell(rst) && !s.det_reset |-> !s.rewrite_en)
    else $error("enable not cleared by reset");

  // Detector reset keeps the level register
  det_keep_a: assert property ($fell(rst) && s.det_reset |-> s.level == $past(s.level, 2))
    else $error("level lost on detector reset");

  // Reserved bits read zero
  resv_zero_a: assert property (ctrl_read_s |=> bus_rdata[6:2] == 5'h00)
    else $error("reserved bits not zero");

  // Enable and flag read back their sources
  ctrl_read_a: assert property (ctrl_read_s |=>
    bus_rdata[`LVDC_EN_BIT] == $past(s.rewrite_en) && bus_rdata[`LVDC_FLAG_BIT] == $past(flag))
    else $error("control read mismatch");

  // Locked level register ignores writes
  level_lock_a: assert property (bus_wr && level_hit && !s.rewrite_en &&
    s.st == lvdc_pkg::LVDC_ST_RUN |=> $stable(s.level))
    else $error("level written while locked");

  // Mask reads one while enabled in combined mode
  mask_read_a: assert property ((ctrl_read_s and (comb_mode && s.rewrite_en)) |=>
    bus_rdata[`LVDC_MASK_BIT])
    else $error("mask not reported");

  // Enable never sets outside combined mode
  enable_gate_a: assert property (s.st == lvdc_pkg::LVDC_ST_RUN && !comb_mode &&
    !s.rewrite_en |=> !s.rewrite_en)
    else $error("enable set outside combined mode");

  // Interrupt mode starts at level 01H with enable clear
  irq_init_a: assert property (s.st == lvdc_pkg::LVDC_ST_LOAD && !s.det_reset &&
    {opt_hi_s, opt_lo_s} == `LVDC_MODE_IRQ_CODE |=> s.level == `LVDC_LEVEL_INIT_IRQ &&
    !s.rewrite_en && detector_internal_reset)
    else $error("interrupt mode start wrong");

  // Internal reset holds while supply stays low
  hold_a: assert property (s.st == lvdc_pkg::LVDC_ST_HOLD && below_s |=>
    detector_internal_reset)
    else $error("internal reset released early");

  // Rising supply gives a one-cycle interrupt
  irq_pulse_a: assert property (rise_s |=> supply_detect_irq ##1 !supply_detect_irq)
    else $error("interrupt not raised");

  // Level change masks the detector for the first 8 cycles of the settling wait
  settle_mask_a: assert property (level_flip_s |=> masked [*8])
    else $error("mask dropped during settling");

  // Control write that leaves bit 7 out of its mask
  sequence ctrl_low_write_s;
    bus_wr && ctrl_hit && !bus_wmask[`LVDC_EN_BIT] && s.st == lvdc_pkg::LVDC_ST_RUN;
  endsequence

  // Whole-byte write to an unlocked level register while running
  sequence level_byte_write_s;
    bus_wr && level_hit && s.rewrite_en && s.st == lvdc_pkg::LVDC_ST_RUN &&
      bus_wmask == 8'hff;
  endsequence

  // Bit writes below bit 7 never touch the enable
  bit_write_a: assert property (ctrl_low_write_s |=> $stable(s.rewrite_en))
    else $error("enable changed by a lower-bit write");

  // Byte write lands on the two level bits
  level_write_a: assert property (level_byte_write_s |=>
    s.level[`LVDC_LMODE_BIT] == $past(bus_wdata[`LVDC_LMODE_BIT]) &&
    s.level[`LVDC_LLEVEL_BIT] == $past(bus_wdata[`LVDC_LLEVEL_BIT]))
    else $error("level write lost");

  // Interrupt mode leaves the hold once the supply is up
  release_a: assert property (s.st == lvdc_pkg::LVDC_ST_HOLD && !below_s |=>
    !detector_internal_reset)
    else $error("internal reset not released");

  // Masked combined mode raises no interrupt
  irq_gate_a: assert property (comb_mode && masked &&
    s.st == lvdc_pkg::LVDC_ST_RUN |=> !supply_detect_irq)
    else $error("interrupt while masked");

  // Off detector reads its flag as zero
  flag_off_a: assert property ((ctrl_read_s and
    (s.mode == lvdc_pkg::LVDC_MODE_OFF)) |=> !bus_rdata[`LVDC_FLAG_BIT])
    else $error("flag set with detector off");

  // Outside combined mode the mask never shows
  mask_idle_a: assert property ((ctrl_read_s and (!comb_mode)) |=>
    !bus_rdata[`LVDC_MASK_BIT])
    else $error("mask shown outside combined mode");

endmodule

`default_nettype wire

// [verification/low_voltage_detect_control_test.sv]
// Self-checking bench of the supply voltage detector control block
`default_nettype none
`include "lvdc_consts.svh"

module low_voltage_detect_control_test;
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic core_clk = 1'b0;
  logic rst = 1'b1; // Held from time zero
  logic reset_by_detector = 1'b0;
  logic supply_below_raw = 1'b0; // Supply healthy unless a case lowers it
  logic detector_mode_opt_hi = 1'b1; // Combined mode first
  logic detector_mode_opt_lo = 1'b0;
  logic [`LVDC_ADDR_W-1:0] bus_addr = 20'h00000;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_wmask = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic supply_detect_irq;
  logic detector_internal_reset;
  logic [7:0] detect_level_select;
  int n_mismatch = 0; // Failed comparisons
  int checks_done = 0; // All comparisons
  int n_irq = 0; // Interrupt pulses seen since last cleared

  // Ordinary register cases: op 0 write, 1 read and compare, 2 idle
  typedef struct {
    logic [1:0] op;
    logic [19:0] addr;
    logic [7:0] wd;
    logic [7:0] wm;
    logic [7:0] exp;
  } lvdc_row_t;
  localparam logic [19:0] CA = `LVDC_CTRL_ADDR;
  localparam logic [19:0] LA = `LVDC_LEVEL_ADDR;
  lvdc_row_t rows [16] = '{
    '{2'h1, CA, 8'h00, 8'h00, 8'h00},
    '{2'h1, LA, 8'h00, 8'h00, 8'h81},
    '{2'h0, LA, 8'h80, 8'hff, 8'h00}, // Refused, rewrite disabled
    '{2'h1, LA, 8'h00, 8'h00, 8'h81},
    '{2'h0, CA, 8'hff, 8'hff, 8'h00}, // Byte write, all ones
    '{2'h1, CA, 8'h00, 8'h00, 8'h82},
    '{2'h0, LA, 8'h80, 8'hff, 8'h00}, // Level bit changes, settle wait starts
    '{2'h1, LA, 8'h00, 8'h00, 8'h80},
    '{2'h0, CA, 8'h00, 8'hff, 8'h00}, // Rewrite off while still settling
    '{2'h1, CA, 8'h00, 8'h00, 8'h02},
    '{2'h2, CA, 8'h00, 8'h00, 8'h00}, // Outlast the settle wait
    '{2'h1, CA, 8'h00, 8'h00, 8'h00},
    '{2'h0, CA, 8'h80, 8'h80, 8'h00}, // Single-bit write of bit 7
    '{2'h1, CA, 8'h00, 8'h00, 8'h82},
    '{2'h0, CA, 8'h00, 8'h7f, 8'h00}, // Bit writes below bit 7 only
    '{2'h1, CA, 8'h00, 8'h00, 8'h82}
  };
  logic [1:0] modes [3] = '{2'h0, 2'h1, 2'h3}; // Every mode but combined
  logic [7:0] mode_lvl [3] = '{8'h81, 8'h01, 8'h81};

  lvdc_top i_lvdc_top (
    .core_clk(core_clk),
    .rst(rst),
    .reset_by_detector(reset_by_detector),
    .supply_below_raw(supply_below_raw),
    .detector_mode_opt_hi(detector_mode_opt_hi),
    .detector_mode_opt_lo(detector_mode_opt_lo),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wmask(bus_wmask),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .supply_detect_irq(supply_detect_irq),
    .detector_internal_reset(detector_internal_reset),
    .detect_level_select(detect_level_select)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 8 ns period
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // Interrupt pulse counter; sees the registered output before it updates
  always @(posedge core_clk) begin
    if (supply_detect_irq === 1'b1) n_irq = n_irq + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, the only place the run ends
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compare one byte, count it, report a difference at once
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Synchronous reset, 6 cycles; straps change under reset only
  task automatic do_reset(input logic [1:0] pair, input logic by_det);
    @(posedge core_clk);
    rst <= 1'b1;
    detector_mode_opt_hi <= pair[1];
    detector_mode_opt_lo <= pair[0];
    reset_by_detector <= by_det;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    reset_by_detector <= 1'b0;
    // First cycle after release is the load step; stay off the bus
    repeat (2) @(posedge core_clk);
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [19:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    bus_wmask <= m;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask

  // One-cycle read; data stands only in the next cycle, then returns to zero
  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1;
    check(bus_rdata, exp, what);
    @(posedge core_clk);
    #1;
    check(bus_rdata, 8'h00, "read data after its cycle");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset(2'h2, 1'b0);
    // Table of ordinary register cases in combined mode
    foreach (rows[i]) begin
      if (rows[i].op == 2'h0) wr_reg(rows[i].addr, rows[i].wd, rows[i].wm);
      else if (rows[i].op == 2'h2) repeat (45) @(posedge core_clk);
      else rd_chk(rows[i].addr, rows[i].exp, "table read");
    end
    rd_chk(20'h00000, 8'h00, "unmapped read");
    // Detector-caused reset keeps rewrite enable and level
    do_reset(2'h2, 1'b1);
    rd_chk(CA, 8'h82, "control after detector reset");
    rd_chk(LA, 8'h80, "level after detector reset");
    // Supply below threshold while masked: flag set, no interrupt
    n_irq = 0;
    @(posedge core_clk);
    supply_below_raw <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk(CA, 8'h83, "flag while below");
    check(8'(n_irq), 8'h00, "interrupt while masked");
    supply_below_raw <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd_chk(CA, 8'h82, "flag after recovery");
    // Ordinary reset clears the control register and reloads the level
    do_reset(2'h2, 1'b0);
    rd_chk(CA, 8'h00, "control after plain reset");
    rd_chk(LA, 8'h81, "level after plain reset");
    // Unmasked fall in combined mode: one interrupt, then masked while settling
    n_irq = 0;
    @(posedge core_clk);
    supply_below_raw <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd_chk(CA, 8'h03, "mask during settling wait");
    check(8'(n_irq), 8'h01, "interrupt on unmasked fall");
    @(posedge core_clk);
    supply_below_raw <= 1'b0;
    // Outside combined mode the enable cannot be set
    foreach (modes[i]) begin
      do_reset(modes[i], 1'b0);
      wr_reg(CA, 8'h80, 8'hff);
      rd_chk(CA, 8'h00, "enable outside combined mode");
      rd_chk(LA, mode_lvl[i], "initial level per mode");
      check(detect_level_select, mode_lvl[i], "level output per mode");
    end
    // Interrupt mode: supply low from power-up holds the internal reset
    @(posedge core_clk);
    supply_below_raw <= 1'b1;
    do_reset(2'h1, 1'b0);
    #1;
    check({7'h00, detector_internal_reset}, 8'h01, "internal reset held");
    rd_chk(LA, 8'h01, "level in interrupt mode");
    wr_reg(CA, 8'h80, 8'hff);
    rd_chk(CA, 8'h01, "control in interrupt mode");
    n_irq = 0;
    @(posedge core_clk);
    supply_below_raw <= 1'b0;
    // Bounded wait for the release
    repeat (20) begin
      if (detector_internal_reset !== 1'b0) begin
        @(posedge core_clk);
        #1;
      end
    end
    if (detector_internal_reset !== 1'b0) begin
      n_mismatch++;
      $display("wrong value at %0t ns: internal reset never released", $time);
    end
    repeat (6) @(posedge core_clk);
    check(8'(n_irq), 8'h00, "release raises no interrupt");
    // Supply dips and recovers: exactly one interrupt
    supply_below_raw <= 1'b1;
    repeat (6) @(posedge core_clk);
    supply_below_raw <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    check(8'(n_irq), 8'h01, "interrupt on recovery");
    check({7'h00, detector_internal_reset}, 8'h00, "no second internal reset");
    // Supply falls again: the system applies its external reset first
    @(posedge core_clk);
    supply_below_raw <= 1'b1;
    do_reset(2'h1, 1'b0);
    #1;
    check({7'h00, detector_internal_reset}, 8'h01, "held again after external reset");
    check(detect_level_select, 8'h01, "level after external reset");
    tally_and_finish();
  end

endmodule

`default_nettype wire
